// >>> dps_host_ctrl.sv
// Host-side controller driving one port of the dual-port RAM with flags
`timescale 1ns/1ps
module dps_host_ctrl
    import dps_pkg::*;
#(
    parameter logic [RETRY_W-1:0] MAX_RETRY = MAX_RETRY_DEF
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic REQ_FLAG,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    output logic RSP_VALID,
    output logic [DATA_W-1:0] RSP_RDATA,
    output logic RSP_BUSY_FAIL,
    output logic CHIP_EN_N,
    output logic READ_WRITE_N,
    output logic OUT_EN_N,
    output logic FLAG_SPACE_SELECT_N,
    output logic [ADDR_W-1:0] LEFT_WORD_INDEX,
    input wire logic [DATA_W-1:0] LEFT_DATA_LINES_IN,
    output logic [DATA_W-1:0] LEFT_DATA_LINES_OUT,
    output logic LEFT_DATA_LINES_OE_N,
    input wire logic BUSY_N_IN,
    input wire logic INT_N_IN,
    output logic INT_SEEN
);
    localparam int SW = DATA_W + 2;
    localparam logic [SW-1:0] SYNC_IDLE = {1'b1, 1'b1, DATA_ZERO};

    // ------------------------------------------------------------------------
    // Pin input synchronisation
    // ------------------------------------------------------------------------
    dps_sync_if #(.W(SW)) pin_sync ();
    assign pin_sync.raw = {INT_N_IN, BUSY_N_IN, LEFT_DATA_LINES_IN};

    dps_sync #(.W(SW), .RESET_VAL(SYNC_IDLE)) u_sync (
        .clk(SYS_CLK),
        .srst(SRST),
        .bus(pin_sync.sink)
    );

    logic [DATA_W-1:0] data_s;
    logic busy_s;
    logic int_s;
    assign data_s = pin_sync.synced[DATA_W-1:0];
    assign busy_s = ~pin_sync.synced[DATA_W];
    assign int_s = ~pin_sync.synced[DATA_W+1];

    // ------------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------------
    dps_state_e state_reg;
    dps_state_e state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [RETRY_W-1:0] retry_reg;
    logic [RETRY_W-1:0] retry_next;
    logic wr_reg;
    logic wr_next;
    logic flag_reg;
    logic flag_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] wdata_next;
    logic busy_hit_reg;
    logic busy_hit_next;

    // Registered pin drive
    logic ce_n_reg;
    logic ce_n_next;
    logic rw_n_reg;
    logic rw_n_next;
    logic oe_n_reg;
    logic oe_n_next;
    logic sem_n_reg;
    logic sem_n_next;
    logic dq_oe_n_reg;
    logic dq_oe_n_next;

    // Response
    logic rsp_valid_reg;
    logic rsp_valid_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic fail_reg;
    logic fail_next;
    logic int_reg;
    logic int_next;

    logic take;
    logic hold_done;
    assign take = REQ_VALID && (state_reg == DPS_IDLE);
    assign hold_done = (cnt_reg == HOLD_LAST);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        retry_next = retry_reg;
        wr_next = wr_reg;
        flag_next = flag_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        busy_hit_next = busy_hit_reg;
        rsp_valid_next = 1'b0;
        rdata_next = rdata_reg;
        fail_next = fail_reg;
        int_next = int_s;
        unique case (state_reg)
            DPS_IDLE: begin
                if (take) begin
                    wr_next = REQ_WRITE;
                    flag_next = REQ_FLAG;
                    // Flags decode only the low index bits
                    addr_next = REQ_FLAG ?
                        {ADDR_ZERO[ADDR_W-1:FLAG_IDX_W], REQ_ADDR[FLAG_IDX_W-1:0]} :
                        REQ_ADDR;
                    wdata_next = REQ_WDATA;
                    retry_next = RETRY_ZERO;
                    state_next = DPS_SETUP;
                end
            end
            DPS_SETUP: begin
                cnt_next = CNT_ZERO;
                busy_hit_next = 1'b0;
                state_next = DPS_ACTIVE;
            end
            DPS_ACTIVE: begin
                cnt_next = cnt_reg + CNT_ONE;
                // Busy means the far port won the same word
                if (busy_s && !flag_reg) begin
                    busy_hit_next = 1'b1;
                end
                if (hold_done) begin
                    state_next = DPS_RELEASE;
                    if ((busy_hit_next) && (retry_reg != MAX_RETRY)) begin
                        retry_next = retry_reg + RETRY_ONE;
                    end else begin
                        rsp_valid_next = 1'b1;
                        fail_next = busy_hit_next;
                        // Flag reads return the state on all lines
                        rdata_next = wr_reg ? rdata_reg : data_s;
                    end
                end
            end
            DPS_RELEASE: begin
                // Loser of arbitration goes round again
                if (busy_hit_reg && (retry_reg != RETRY_ZERO) && !rsp_valid_reg) begin
                    state_next = DPS_SETUP;
                end else begin
                    state_next = DPS_IDLE;
                end
            end
        endcase
    end

    // Pin levels follow the next state so they change on the same edge
    always_comb begin
        ce_n_next = 1'b1;
        sem_n_next = 1'b1;
        rw_n_next = 1'b1;
        oe_n_next = 1'b1;
        dq_oe_n_next = 1'b1;
        unique case (state_next)
            DPS_IDLE: begin
                // Both selects high parks the memory port in standby
                ce_n_next = 1'b1;
            end
            DPS_SETUP: begin
                ce_n_next = flag_next;
                sem_n_next = ~flag_next;
            end
            DPS_ACTIVE: begin
                ce_n_next = flag_next;
                sem_n_next = ~flag_next;
                rw_n_next = ~wr_next;
                oe_n_next = wr_next;
                dq_oe_n_next = ~wr_next;
            end
            DPS_RELEASE: begin
                // Data held one cycle past the write strobe
                dq_oe_n_next = ~wr_reg;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_reg <= DPS_IDLE;
            cnt_reg <= CNT_ZERO;
            retry_reg <= RETRY_ZERO;
            wr_reg <= 1'b0;
            flag_reg <= 1'b0;
            addr_reg <= ADDR_ZERO;
            wdata_reg <= DATA_ZERO;
            busy_hit_reg <= 1'b0;
            ce_n_reg <= 1'b1;
            rw_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            sem_n_reg <= 1'b1;
            dq_oe_n_reg <= 1'b1;
            rsp_valid_reg <= 1'b0;
            rdata_reg <= DATA_ZERO;
            fail_reg <= 1'b0;
            int_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            retry_reg <= retry_next;
            wr_reg <= wr_next;
            flag_reg <= flag_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            busy_hit_reg <= busy_hit_next;
            ce_n_reg <= ce_n_next;
            rw_n_reg <= rw_n_next;
            oe_n_reg <= oe_n_next;
            sem_n_reg <= sem_n_next;
            dq_oe_n_reg <= dq_oe_n_next;
            rsp_valid_reg <= rsp_valid_next;
            rdata_reg <= rdata_next;
            fail_reg <= fail_next;
            int_reg <= int_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign REQ_READY = (state_reg == DPS_IDLE);
    assign RSP_VALID = rsp_valid_reg;
    assign RSP_RDATA = rdata_reg;
    assign RSP_BUSY_FAIL = fail_reg;
    assign CHIP_EN_N = ce_n_reg;
    assign READ_WRITE_N = rw_n_reg;
    assign OUT_EN_N = oe_n_reg;
    assign FLAG_SPACE_SELECT_N = sem_n_reg;
    assign LEFT_WORD_INDEX = addr_reg;
    assign LEFT_DATA_LINES_OUT = wdata_reg;
    assign LEFT_DATA_LINES_OE_N = dq_oe_n_reg;
    assign INT_SEEN = int_reg;
endmodule // dps_host_ctrl

// >>> dps_pkg.sv
// Constants, timing figures and state encoding for the dual-port RAM port controller
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package dps_pkg;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 9;
    localparam int FLAG_IDX_W = 3;
    localparam int SYNC_STAGES = 2;

    localparam int CLK_PERIOD_NS = 40;
    localparam int ACCESS_NS = 12;
    localparam int ACCESS_RAW = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_RAW < 1) ? 1 : ACCESS_RAW;
    // Read data and busy both travel through the input synchroniser
    localparam int HOLD_CYC = ACCESS_CYC + SYNC_STAGES;

    localparam int CNT_W = 4;
    localparam int RETRY_W = 4;
    localparam logic [RETRY_W-1:0] MAX_RETRY_DEF = 4'h8;

    localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 9'h000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
    localparam logic [RETRY_W-1:0] RETRY_ZERO = 4'h0;
    localparam logic [RETRY_W-1:0] RETRY_ONE = 4'h1;

    typedef enum logic [3:0] {
        DPS_IDLE = 4'h1,
        DPS_SETUP = 4'h2,
        DPS_ACTIVE = 4'h4,
        DPS_RELEASE = 4'h8
    } dps_state_e;

endpackage

// >>> dps_sync_if.sv
// Bundle of raw pin levels and their synchronised copies
`timescale 1ns/1ps
interface dps_sync_if #(parameter int W = 11);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport src (output raw, input synced);
    modport sink (input raw, output synced);
endinterface

// >>> dps_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dps_sync
    import dps_pkg::*;
#(
    parameter int W = 11,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic srst,
    dps_sync_if.sink bus
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] hold_reg;
    logic [W-1:0] hold_next;

    always_comb begin
        meta_next = bus.raw;
        hold_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_reg <= RESET_VAL;
            hold_reg <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            hold_reg <= hold_next;
        end
    end

    assign bus.synced = hold_reg;
endmodule // dps_sync

// >>> dps_checker.sv
// Concurrent checks on the host controller pins
`timescale 1ns/1ps
module dps_checker
    import dps_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic REQ_FLAG,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic RSP_VALID,
    input wire logic CHIP_EN_N,
    input wire logic READ_WRITE_N,
    input wire logic OUT_EN_N,
    input wire logic FLAG_SPACE_SELECT_N,
    input wire logic [ADDR_W-1:0] LEFT_WORD_INDEX,
    input wire logic LEFT_DATA_LINES_OE_N,
    input wire logic INT_N_IN,
    input wire logic INT_SEEN
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    sequence s_take;
        REQ_VALID && REQ_READY;
    endsequence
    sequence s_ftake;
        REQ_VALID && REQ_READY && REQ_FLAG;
    endsequence
    property p_excl;
        !(!CHIP_EN_N && !FLAG_SPACE_SELECT_N);
    endproperty
    a_excl: assert property (p_excl) else $error("chip and flag select both low");
    property p_idle;
        REQ_READY |-> CHIP_EN_N && FLAG_SPACE_SELECT_N && OUT_EN_N && LEFT_DATA_LINES_OE_N;
    endproperty
    a_idle: assert property (p_idle) else $error("idle port not deselected");
    property p_nofight;
        !OUT_EN_N |-> LEFT_DATA_LINES_OE_N;
    endproperty
    a_nofight: assert property (p_nofight) else $error("data driven during read");
    property p_wdrive;
        !READ_WRITE_N |-> !LEFT_DATA_LINES_OE_N;
    endproperty
    a_wdrive: assert property (p_wdrive) else $error("write without data");
    property p_mem;
        s_take ##0 !REQ_FLAG |=> !CHIP_EN_N && FLAG_SPACE_SELECT_N;
    endproperty
    a_mem: assert property (p_mem) else $error("memory access strobes wrong");
    property p_flag;
        s_ftake |=> CHIP_EN_N && !FLAG_SPACE_SELECT_N;
    endproperty
    a_flag: assert property (p_flag) else $error("flag access strobes wrong");
    property p_fwr;
        s_ftake ##0 REQ_WRITE |=> ##1 !READ_WRITE_N [*3];
    endproperty
    a_fwr: assert property (p_fwr) else $error("flag write strobe short");
    property p_frsp;
        s_ftake |-> ##5 RSP_VALID;
    endproperty
    a_frsp: assert property (p_frsp) else $error("flag answer late");
    property p_addr;
        s_take |=> LEFT_WORD_INDEX == ($past(REQ_FLAG) ?
            {{(ADDR_W-FLAG_IDX_W){1'b0}}, $past(REQ_ADDR[FLAG_IDX_W-1:0])} : $past(REQ_ADDR));
    endproperty
    a_addr: assert property (p_addr) else $error("word index wrong");
    property p_int;
        INT_N_IN ##1 !INT_N_IN [*4] |-> INT_SEEN;
    endproperty
    a_int: assert property (p_int) else $error("interrupt not seen");
endmodule // dps_checker
bind dps_host_ctrl dps_checker u_chk (.SYS_CLK, .SRST, .REQ_VALID, .REQ_READY, .REQ_WRITE,
    .REQ_FLAG, .REQ_ADDR, .RSP_VALID, .CHIP_EN_N, .READ_WRITE_N, .OUT_EN_N,
    .FLAG_SPACE_SELECT_N, .LEFT_WORD_INDEX, .LEFT_DATA_LINES_OE_N, .INT_N_IN, .INT_SEEN);

// >>> dps_mem_model.sv
// Behavioural dual-port memory with flags, one port modelled
`timescale 1ns/1ps
module dps_mem_model
    import dps_pkg::*;
(
    input wire logic ce_n,
    input wire logic rw_n,
    input wire logic oe_n,
    input wire logic sem_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] ctl_d,
    input wire logic ctl_oe_n,
    input wire logic hold_busy,
    output logic [DATA_W-1:0] wire_d,
    output logic busy_n
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [7:0] flag = 8'h00;
    logic [DATA_W-1:0] last = '0;
    logic rd;
    // Master strap: busy is a driven output
    assign busy_n = !hold_busy;
    assign rd = rw_n && !oe_n && (!ce_n || !sem_n);
    always @* begin
        if (!ctl_oe_n) begin
            wire_d = ctl_d;
        end else if (rd) begin
            wire_d = sem_n ? mem[addr] : {DATA_W{flag[addr[2:0]]}};
        end else begin
            // Floating lines must not look like held data
            wire_d = ~last;
        end
    end
    always @(wire_d) if (!ctl_oe_n || rd) last = wire_d;
    always @* begin
        // Losing port's write is dropped
        if (!rw_n && !ce_n && sem_n && busy_n) mem[addr] = wire_d;
        if (!rw_n && ce_n && !sem_n) flag[addr[2:0]] = wire_d[0];
    end
endmodule // dps_mem_model

// >>> dps_host_ctrl_tb.sv
// Self-checking bench for the host port controller
`timescale 1ns/1ps
module dps_host_ctrl_tb
    import dps_pkg::*;
;
    typedef struct {logic w; logic f; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] e;} dps_row_s;
    dps_row_s rows [8] = '{
        '{1'b1, 1'b0, 14'h0000, 9'h1a5, 9'h000},
        '{1'b1, 1'b0, 14'h3fff, 9'h05a, 9'h000},
        '{1'b0, 1'b0, 14'h0000, 9'h000, 9'h1a5},
        '{1'b0, 1'b0, 14'h3fff, 9'h000, 9'h05a},
        '{1'b1, 1'b1, 14'h0007, 9'h001, 9'h000},
        '{1'b1, 1'b1, 14'h0000, 9'h1fe, 9'h000},
        '{1'b0, 1'b1, 14'h0007, 9'h000, 9'h1ff},
        '{1'b0, 1'b1, 14'h0000, 9'h000, 9'h000}};
    logic clk, srst, valid, wr, fl, hold, int_n;
    logic rdy, rsp_v, fail, ce_n, rw_n, oe_n, sem_n, doe_n, busy_n, int_seen;
    logic [ADDR_W-1:0] addr, idx;
    logic [DATA_W-1:0] wdata, rdata, dout, din;
    int err_total = 0;
    int n_tests = 0;
    dps_host_ctrl #(.MAX_RETRY(4'h1)) uut (.SYS_CLK(clk), .SRST(srst), .REQ_VALID(valid),
        .REQ_READY(rdy), .REQ_WRITE(wr), .REQ_FLAG(fl), .REQ_ADDR(addr), .REQ_WDATA(wdata),
        .RSP_VALID(rsp_v), .RSP_RDATA(rdata), .RSP_BUSY_FAIL(fail), .CHIP_EN_N(ce_n),
        .READ_WRITE_N(rw_n), .OUT_EN_N(oe_n), .FLAG_SPACE_SELECT_N(sem_n),
        .LEFT_WORD_INDEX(idx), .LEFT_DATA_LINES_IN(din), .LEFT_DATA_LINES_OUT(dout),
        .LEFT_DATA_LINES_OE_N(doe_n), .BUSY_N_IN(busy_n), .INT_N_IN(int_n),
        .INT_SEEN(int_seen));
    dps_mem_model u_mem (.ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .sem_n(sem_n), .addr(idx),
        .ctl_d(dout), .ctl_oe_n(doe_n), .hold_busy(hold), .wire_d(din), .busy_n(busy_n));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic results();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_n(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            err_total++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // Request held from a falling edge until the take edge
    task automatic xfer(input dps_row_s r, output int cyc);
        int k;
        k = 0;
        @(negedge clk);
        while (rdy !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        {wr, fl, addr, wdata} = {r.w, r.f, r.a, r.d};
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        cyc = 1;
        while (rsp_v !== 1'b1 && cyc < 50) begin
            @(negedge clk);
            cyc++;
        end
        if (k >= 50 || cyc >= 50) begin
            err_total++;
            results();
        end
    endtask
    initial begin
        int c;
        srst = 1'b1;
        {valid, wr, fl, hold} = 4'h0;
        int_n = 1'b1;
        addr = '0;
        wdata = '0;
        repeat (8) @(negedge clk);
        chk("ready in reset", 9'h001, {8'h00, rdy});
        srst = 1'b0;
        foreach (rows[i]) begin
            xfer(rows[i], c);
            chk_n("answer cycles", 5, c);
            chk("busy fail", 9'h000, {8'h00, fail});
            if (!rows[i].w) chk("read data", rows[i].e, rdata);
        end
        hold = 1'b1;
        xfer('{1'b1, 1'b0, 14'h0000, 9'h0ff, 9'h000}, c);
        chk_n("retry cycles", 10, c);
        chk("busy fail", 9'h001, {8'h00, fail});
        xfer(rows[6], c);
        chk_n("flag under busy", 5, c);
        chk("flag under busy", 9'h1ff, rdata);
        hold = 1'b0;
        xfer(rows[2], c);
        chk("lost write", 9'h1a5, rdata);
        int_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("int seen", 9'h001, {8'h00, int_seen});
        int_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("int clear", 9'h000, {8'h00, int_seen});
        {wr, fl, valid} = 3'h1;
        @(negedge clk);
        valid = 1'b0;
        @(negedge clk);
        srst = 1'b1;
        repeat (3) @(negedge clk);
        chk("pins in reset", 9'h01f, {4'h0, rdy, ce_n, oe_n, sem_n, doe_n});
        chk("answer in reset", 9'h000, rdata);
        srst = 1'b0;
        xfer(rows[6], c);
        chk_n("answer after reset", 5, c);
        chk("flag after reset", 9'h1ff, rdata);
        results();
    end
endmodule // dps_host_ctrl_tb
